// ### shared/flt_pkg.sv
// constants for the fault-log trigger and record block
package flt_pkg;
	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [6:0] IDX_LOG_SLOT_TRK = 7'h00;
	localparam logic [6:0] IDX_LOG_CH_LOW = 7'h01;
	localparam logic [6:0] IDX_LOG_CH_HIGH = 7'h02;
	localparam logic [6:0] IDX_LOG_CTRL = 7'h47;
	localparam logic [6:0] IDX_OV_LOG_EN_HIGH = 7'h4A;
	localparam logic [6:0] IDX_EW_LOG_EN_LOW = 7'h4B;
	localparam logic [6:0] IDX_EW_LOG_EN_HIGH = 7'h4C;
	localparam logic [6:0] IDX_IRQ_STATUS = 7'h50;
	localparam logic [6:0] IDX_IRQ_MASK = 7'h51;
	localparam logic [6:0] IDX_TRK_CLOSED_LOOP = 7'h52;

	// ----------------------------------------------------------------
	// field layout
	// ----------------------------------------------------------------
	localparam int SLOT_LSB = 0;
	localparam int SLOT_W = 4;
	localparam int TRK_LSB = 4;
	localparam int TRK_W = 4;
	localparam int OV_EN_LSB = 5;
	localparam int OV_EN_FIRST_CH = 9;
	localparam int OV_EN_W = 3;
	localparam int EW_HIGH_W = 4;
	localparam int LOGCTL_W = 2;
	localparam logic [1:0] LOGCTL_DISABLED = 2'h3;
	localparam int IRQ_W = 3;
	localparam int IRQ_LOG = 0;
	localparam int IRQ_SEQ = 1;
	localparam int IRQ_TRK = 2;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_LOG_SLOT_TRK = 8'hF0;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
endpackage

// ### shared/flt_chan_if.sv
// per-channel carrier between the top and the trigger cell
`timescale 1ns/1ps
interface flt_chan_if;
	logic ov;
	logic ew;
	logic ov_en;
	logic ew_en;
	logic fire;
	modport trig (input ov, input ew, input ov_en, input ew_en, output fire);
	modport top (output ov, output ew, output ov_en, output ew_en, input fire);
endinterface

// ### verilog/flt_chan_trig.sv
// per-channel trigger cell: overvoltage rise and early-warning crossing
`timescale 1ns/1ps
module flt_chan_trig (
	input wire logic core_clk,
	input wire logic nrst,
	flt_chan_if.trig ch
);
	logic ov_q_r;
	logic ew_q_r;
	logic ov_rise;
	logic ew_cross;

	// ----------------------------------------------------------------
	// previous comparator levels
	// ----------------------------------------------------------------
	// comparators share core_clk, so no synchroniser is needed here
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			ov_q_r <= 1'b0;
			ew_q_r <= 1'b0;
		end else begin
			ov_q_r <= ch.ov;
			ew_q_r <= ch.ew;
		end
	end

	// only a fresh rise counts, a held level fires once
	assign ov_rise = ch.ov & ~ov_q_r;
	// either direction counts as a crossing
	assign ew_cross = ch.ew ^ ew_q_r;
	assign ch.fire = (ov_rise & ch.ov_en) | (ew_cross & ch.ew_en);
endmodule // flt_chan_trig

// ### verilog/flt_log_top.sv
// fault-log trigger selection and record capture with register slave
//
// Summary of operation
// - ov enable bits 5..7 start a log when channels 10..12 rise above their overvoltage threshold.
// - early-warning enable bit n of the low byte starts a log when channel n+1 crosses its threshold either way.
// - bits 0..3 of the high early-warning byte do the same for channels 9..12, bits 7..4 are unused.
// - a log writes the failing sequencing slot into bits 3..0 of log byte 0.
// - bits 4..7 of log byte 0 are active-low tracking-fault flags for channels 1..4.
// - log byte 1 bit n is set when channel n+1 had a fault.
// - a sequencing-time threshold fault drops all enable outputs even with logging off, and stores the slot unless logging is off.
// - a tracking fault on a closed-loop channel logs and clears its flag unless logging is off.
`timescale 1ns/1ps
module flt_log_top #(
	parameter int NUM_CH = 12,
	parameter int NUM_TRK = 4
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [8:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [NUM_CH-1:0] monitored_input_ov,
	input wire logic [NUM_CH-1:0] monitored_input_ew,
	input wire logic seq_fault,
	input wire logic [3:0] seq_slot,
	input wire logic seq_start,
	input wire logic [NUM_TRK-1:0] tracking_sense_fault,
	output logic en_out_off,
	output logic log_event,
	output logic irq
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic wait_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic [7:0] log_slot_trk_r;
	logic [7:0] log_ch_low_r;
	logic [7:0] log_ch_high_r;
	logic [1:0] log_ctrl_r;
	logic [7:0] ov_en_r;
	logic [7:0] ew_en_low_r;
	logic [3:0] ew_en_high_r;
	logic [2:0] irq_status_r;
	logic [2:0] irq_status_nxt;
	logic [2:0] irq_mask_r;
	logic [3:0] trk_closed_r;
	logic en_off_r;
	logic log_event_r;
	logic irq_r;

	logic req;
	logic acc_done;
	logic wr_lane0;
	logic [6:0] reg_idx;
	logic word_ok;
	logic wr_log_ctrl;
	logic wr_ov_en;
	logic wr_ew_low;
	logic wr_ew_high;
	logic wr_irq_status;
	logic wr_irq_mask;
	logic wr_trk_closed;
	logic [7:0] wbyte;

	logic [15:0] ov_en_ch;
	logic [15:0] ew_en_ch;
	logic [15:0] ch_fire;
	logic [15:0] ch_fire_pad;
	logic logging_on;
	logic any_ch_fire;
	logic trk_hit_any;
	logic [3:0] trk_hit;
	logic trigger;
	logic [3:0] slot_nxt;
	logic [3:0] trk_flags_nxt;
	logic [2:0] irq_set;
	logic [2:0] irq_clr;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	// byte address is four times the register index, low bits must be zero
	assign req = avs_read | avs_write;
	assign acc_done = req & ~wait_r;
	assign reg_idx = avs_address[8:2];
	assign word_ok = (avs_address[1:0] == 2'h0);
	assign wr_lane0 = avs_write & acc_done & word_ok & avs_byteenable[0];
	assign wbyte = avs_writedata[7:0];
	assign wr_log_ctrl = wr_lane0 & (reg_idx == flt_pkg::IDX_LOG_CTRL);
	assign wr_ov_en = wr_lane0 & (reg_idx == flt_pkg::IDX_OV_LOG_EN_HIGH);
	assign wr_ew_low = wr_lane0 & (reg_idx == flt_pkg::IDX_EW_LOG_EN_LOW);
	assign wr_ew_high = wr_lane0 & (reg_idx == flt_pkg::IDX_EW_LOG_EN_HIGH);
	assign wr_irq_status = wr_lane0 & (reg_idx == flt_pkg::IDX_IRQ_STATUS);
	assign wr_irq_mask = wr_lane0 & (reg_idx == flt_pkg::IDX_IRQ_MASK);
	assign wr_trk_closed = wr_lane0 & (reg_idx == flt_pkg::IDX_TRK_CLOSED_LOOP);

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	// unmapped or misaligned addresses read as zero
	always_comb begin
		rdata_nxt = flt_pkg::RD_UNMAPPED;
		if (word_ok) begin
			case (reg_idx)
				flt_pkg::IDX_LOG_SLOT_TRK: rdata_nxt[7:0] = log_slot_trk_r;
				flt_pkg::IDX_LOG_CH_LOW: rdata_nxt[7:0] = log_ch_low_r;
				flt_pkg::IDX_LOG_CH_HIGH: rdata_nxt[7:0] = log_ch_high_r;
				flt_pkg::IDX_LOG_CTRL: rdata_nxt[1:0] = log_ctrl_r;
				flt_pkg::IDX_OV_LOG_EN_HIGH: rdata_nxt[7:0] = ov_en_r;
				flt_pkg::IDX_EW_LOG_EN_LOW: rdata_nxt[7:0] = ew_en_low_r;
				flt_pkg::IDX_EW_LOG_EN_HIGH: rdata_nxt[3:0] = ew_en_high_r;
				flt_pkg::IDX_IRQ_STATUS: rdata_nxt[2:0] = irq_status_r;
				flt_pkg::IDX_IRQ_MASK: rdata_nxt[2:0] = irq_mask_r;
				flt_pkg::IDX_TRK_CLOSED_LOOP: rdata_nxt[3:0] = trk_closed_r;
				default: rdata_nxt = flt_pkg::RD_UNMAPPED;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// waitrequest and read data
	// ----------------------------------------------------------------
	// one wait cycle per access; data is loaded as waitrequest drops
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			wait_r <= 1'b1;
			rdata_r <= flt_pkg::RD_UNMAPPED;
		end else begin
			wait_r <= ~(req & wait_r);
			if (req & wait_r) begin
				rdata_r <= rdata_nxt;
			end
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			log_ctrl_r <= 2'h0;
			ov_en_r <= flt_pkg::RST_BYTE;
			ew_en_low_r <= flt_pkg::RST_BYTE;
			ew_en_high_r <= 4'h0;
			irq_mask_r <= 3'h0;
			trk_closed_r <= 4'h0;
		end else begin
			if (wr_log_ctrl) begin
				log_ctrl_r <= wbyte[1:0];
			end
			if (wr_ov_en) begin
				ov_en_r <= wbyte;
			end
			if (wr_ew_low) begin
				ew_en_low_r <= wbyte;
			end
			if (wr_ew_high) begin
				ew_en_high_r <= wbyte[3:0];
			end
			if (wr_irq_mask) begin
				irq_mask_r <= wbyte[2:0];
			end
			if (wr_trk_closed) begin
				trk_closed_r <= wbyte[3:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// per-channel enable mapping
	// ----------------------------------------------------------------
	// only channels 10..12 have an overvoltage enable in this block
	assign ov_en_ch = {4'h0, ov_en_r[7:5], 9'h000};
	// absent channels on a narrow variant are masked by the generate below
	assign ew_en_ch = {4'h0, ew_en_high_r, ew_en_low_r};

	// ----------------------------------------------------------------
	// trigger cells
	// ----------------------------------------------------------------
	flt_chan_if ch_if[NUM_CH] ();

	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_ch
			if (g < NUM_CH) begin : g_live
				assign ch_if[g].ov = monitored_input_ov[g];
				assign ch_if[g].ew = monitored_input_ew[g];
				assign ch_if[g].ov_en = ov_en_ch[g];
				assign ch_if[g].ew_en = ew_en_ch[g];
				assign ch_fire[g] = ch_if[g].fire;
				flt_chan_trig u_trig (
					.core_clk(core_clk),
					.nrst(nrst),
					.ch(ch_if[g])
				);
			end else begin : g_absent
				assign ch_fire[g] = 1'b0;
			end
		end
	endgenerate

	assign ch_fire_pad = ch_fire;

	// ----------------------------------------------------------------
	// event combination
	// ----------------------------------------------------------------
	assign logging_on = (log_ctrl_r != flt_pkg::LOGCTL_DISABLED);
	assign trk_hit = tracking_sense_fault[3:0] & trk_closed_r;
	assign trk_hit_any = |trk_hit;
	assign any_ch_fire = |ch_fire_pad;
	assign trigger = logging_on & (any_ch_fire | seq_fault | trk_hit_any);
	// slot only meaningful for a sequencing fault
	assign slot_nxt = seq_fault ? seq_slot : 4'h0;
	// active low: a zero marks the failed tracking channel
	assign trk_flags_nxt = ~trk_hit;

	// ----------------------------------------------------------------
	// log record capture
	// ----------------------------------------------------------------
	// every byte loads on the same edge, so a readout is coherent
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			log_slot_trk_r <= flt_pkg::RST_LOG_SLOT_TRK;
			log_ch_low_r <= flt_pkg::RST_BYTE;
			log_ch_high_r <= flt_pkg::RST_BYTE;
		end else if (trigger) begin
			log_slot_trk_r <= {trk_flags_nxt, slot_nxt};
			log_ch_low_r <= ch_fire_pad[7:0];
			log_ch_high_r <= {4'h0, ch_fire_pad[11:8]};
		end
	end

	// ----------------------------------------------------------------
	// enable-output shutdown and event strobe
	// ----------------------------------------------------------------
	// shutdown does not depend on logging being on; a new power-up clears it
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			en_off_r <= 1'b0;
			log_event_r <= 1'b0;
		end else begin
			if (seq_fault) begin
				en_off_r <= 1'b1;
			end else if (seq_start) begin
				en_off_r <= 1'b0;
			end
			log_event_r <= trigger;
		end
	end

	// ----------------------------------------------------------------
	// interrupt status and output
	// ----------------------------------------------------------------
	assign irq_set = {trk_hit_any, seq_fault, trigger};
	assign irq_clr = wr_irq_status ? wbyte[2:0] : 3'h0;
	// set beats clear so an event in the clearing cycle survives
	assign irq_status_nxt = (irq_status_r & ~irq_clr) | irq_set;

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			irq_status_r <= 3'h0;
			irq_r <= 1'b0;
		end else begin
			irq_status_r <= irq_status_nxt;
			irq_r <= |(irq_status_nxt & irq_mask_r);
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign avs_readdata = rdata_r;
	assign avs_waitrequest = wait_r;
	assign en_out_off = en_off_r;
	assign log_event = log_event_r;
	assign irq = irq_r;
endmodule // flt_log_top

// ### verification/flt_src_model.sv
// comparator and sequencer stand-in feeding the fault-log block
`timescale 1ns/1ps
module flt_src_model (
	input wire logic core_clk,
	input wire logic [11:0] req_ov,
	input wire logic [11:0] req_ew,
	input wire logic req_seq,
	input wire logic [3:0] req_slot,
	input wire logic req_start,
	input wire logic [3:0] req_trk,
	output logic [11:0] ov,
	output logic [11:0] ew,
	output logic seq_fault,
	output logic [3:0] seq_slot,
	output logic seq_start,
	output logic [3:0] trk
);
	// quiet levels until the first edge
	initial begin
		{ov, ew, seq_fault, seq_slot, seq_start, trk} = '0;
	end
	// one cycle of comparator latency; slot lines are junk outside a fault
	always @(posedge core_clk) begin
		{ov, ew, seq_fault, seq_start, trk} <= {req_ov, req_ew, req_seq, req_start, req_trk};
		seq_slot <= req_seq ? req_slot : ~seq_slot;
	end
endmodule // flt_src_model

// ### verification/flt_log_checker.sv
// port assertions for the fault-log block
`timescale 1ns/1ps
module flt_log_checker #(
	parameter int NUM_CH = 12,
	parameter int NUM_TRK = 4
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [8:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [NUM_CH-1:0] monitored_input_ov,
	input wire logic [NUM_CH-1:0] monitored_input_ew,
	input wire logic seq_fault,
	input wire logic seq_start,
	input wire logic [NUM_TRK-1:0] tracking_sense_fault,
	input wire logic en_out_off,
	input wire logic log_event
);
	logic [1:0] ctl_r;
	logic [NUM_CH-1:0] ov_r;
	logic [NUM_CH-1:0] ew_r;
	// any cause at all; closed-loop selection is not visible here
	wire cause_w = seq_fault | (|tracking_sense_fault) | (|(monitored_input_ov & ~ov_r))
		| (|(monitored_input_ew ^ ew_r));
	// shadow of log control and last comparator levels
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			ctl_r <= 2'h0;
			{ov_r, ew_r} <= '0;
		end else begin
			{ov_r, ew_r} <= {monitored_input_ov, monitored_input_ew};
			if (avs_write && !avs_waitrequest && avs_address == {flt_pkg::IDX_LOG_CTRL, 2'h0}) ctl_r <= avs_writedata[1:0];
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence req_s;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence ans_s;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	wait_one_a: assert property (req_s |=> ans_s) else $error("bus answer late");
	idle_wait_a: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
		else $error("answer without request");
	rd_upper_a: assert property (!avs_waitrequest && avs_read |-> avs_readdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	evt_cause_a: assert property (log_event |-> $past(cause_w)) else $error("log without cause");
	log_block_a: assert property (ctl_r == flt_pkg::LOGCTL_DISABLED |=> !log_event)
		else $error("log while disabled");
	seq_log_a: assert property (seq_fault && ctl_r != flt_pkg::LOGCTL_DISABLED |=> log_event)
		else $error("seq fault not logged");
	en_set_a: assert property (seq_fault |=> en_out_off) else $error("enables not dropped");
	en_hold_a: assert property (en_out_off && !seq_start |=> en_out_off) else $error("enables back early");
	en_clr_a: assert property (seq_start && !seq_fault |=> !en_out_off) else $error("enables stuck off");
endmodule // flt_log_checker
bind flt_log_top flt_log_checker #(.NUM_CH(NUM_CH), .NUM_TRK(NUM_TRK)) u_chk (.core_clk(core_clk), .nrst(nrst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .monitored_input_ov(monitored_input_ov),
	.monitored_input_ew(monitored_input_ew), .seq_fault(seq_fault), .seq_start(seq_start),
	.tracking_sense_fault(tracking_sense_fault), .en_out_off(en_out_off), .log_event(log_event));

// ### verification/test_flt_log_top.sv
// self-checking bench for the fault-log block
`timescale 1ns/1ps
module test_flt_log_top;
	logic core_clk = 1'b0;
	logic nrst, avs_read, avs_write, avs_waitrequest, en_out_off, log_event, irq;
	logic seq_fault, seq_start, req_seq, req_start;
	logic [8:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [11:0] ov, ew, req_ov, req_ew, eb;
	logic [3:0] seq_slot, trk, req_slot, req_trk, sl, be;
	logic [7:0] oe;
	int n_mismatch = 0;
	int tests_run = 0;
	flt_log_top uut (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .monitored_input_ov(ov), .monitored_input_ew(ew), .seq_fault(seq_fault),
		.seq_slot(seq_slot), .seq_start(seq_start), .tracking_sense_fault(trk), .en_out_off(en_out_off),
		.log_event(log_event), .irq(irq));
	flt_src_model src (.core_clk(core_clk), .req_ov(req_ov), .req_ew(req_ew), .req_seq(req_seq), .req_slot(req_slot),
		.req_start(req_start), .req_trk(req_trk), .ov(ov), .ew(ew), .seq_fault(seq_fault), .seq_slot(seq_slot),
		.seq_start(seq_start), .trk(trk));
	// expected record bytes
	function automatic logic [7:0] f_b0(input logic [3:0] slot, input logic [3:0] hit);
		return {~hit, slot};
	endfunction
	function automatic logic [11:0] f_ch(input int n);
		return 12'h1 << n;
	endfunction
	task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_bit(input string nm, input logic e, input logic g);
		chk_reg(nm, {31'h0, e}, {31'h0, g});
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// one bus cycle, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [6:0] idx, input logic [7:0] d);
		int i;
		avs_address <= {idx, 2'h0};
		avs_writedata <= {24'h0, d};
		avs_write <= wr;
		avs_read <= !wr;
		for (i = 0; i < 20; i++) begin
			@(posedge core_clk);
			if (avs_waitrequest === 1'b0) break;
		end
		rd = avs_readdata;
		if (i == 20) begin
			n_mismatch++;
			close_out();
		end
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rdc(input string nm, input logic [6:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00);
		chk_reg(nm, {24'h0, e}, rd);
	endtask
	task automatic rec(input logic [7:0] b0, input logic [11:0] ch);
		rdc("log byte 0", flt_pkg::IDX_LOG_SLOT_TRK, b0);
		rdc("log byte 1", flt_pkg::IDX_LOG_CH_LOW, ch[7:0]);
		rdc("log byte 2", flt_pkg::IDX_LOG_CH_HIGH, {4'h0, ch[11:8]});
	endtask
	// pulse requests last one cycle; watch a fixed window for the log pulse
	task automatic evt(input string nm, input logic e);
		int i;
		logic s;
		s = 1'b0;
		for (i = 0; i < 6; i++) begin
			@(posedge core_clk);
			if (i == 0) {req_seq, req_trk, req_start} <= '0;
			if (log_event === 1'b1) s = 1'b1;
		end
		chk_bit(nm, e, s);
	endtask
	initial begin
		forever #2 core_clk = ~core_clk;
	end
	initial begin
		#400000;
		n_mismatch++;
		close_out();
	end
	initial begin
		{nrst, avs_read, avs_write, avs_address, avs_writedata} = '0;
		{req_ov, req_ew, req_seq, req_slot, req_start, req_trk} = '0;
		be = 4'hF;
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		void'($urandom(32'hDE4D));
		// reset values, read-only log, unmapped hole
		bus(1'b1, flt_pkg::IDX_LOG_SLOT_TRK, 8'h00);
		rec(flt_pkg::RST_LOG_SLOT_TRK, 12'h0);
		// a write without lane 0 must leave the register alone
		be <= 4'hE;
		bus(1'b1, flt_pkg::IDX_EW_LOG_EN_LOW, 8'hFF);
		be <= 4'hF;
		rdc("ew low", flt_pkg::IDX_EW_LOG_EN_LOW, flt_pkg::RST_BYTE);
		rdc("unmapped", 7'h30, 8'h00);
		$display("test reset done");
		// random early-warning enables, both crossing directions
		eb = 12'($urandom) | 12'h801;
		bus(1'b1, flt_pkg::IDX_EW_LOG_EN_LOW, eb[7:0]);
		bus(1'b1, flt_pkg::IDX_EW_LOG_EN_HIGH, {4'hF, eb[11:8]});
		bus(1'b1, flt_pkg::IDX_IRQ_MASK, 8'h01);
		rdc("ew high", flt_pkg::IDX_EW_LOG_EN_HIGH, {4'h0, eb[11:8]});
		for (int n = 0; n < 24; n++) begin
			req_ew[n/2] <= ~req_ew[n/2];
			evt("ew crossing", eb[n/2]);
			if (eb[n/2]) rec(f_b0(4'h0, 4'h0), f_ch(n/2));
		end
		$display("test early warning done");
		// overvoltage rise logs, fall does not
		for (int k = 0; k < 2; k++) begin
			oe = k ? 8'h40 : 8'hB0; // bit 4 is channel 9, not ours: must stay silent
			bus(1'b1, flt_pkg::IDX_OV_LOG_EN_HIGH, oe);
			for (int n = 8; n < 12; n++) begin
				req_ov[n] <= 1'b1;
				evt("ov rise", oe[n-4] && n > 8);
				if (oe[n-4] && n > 8) rec(f_b0(4'h0, 4'h0), f_ch(n));
				req_ov[n] <= 1'b0;
				evt("ov fall", 1'b0);
			end
		end
		$display("test overvoltage done");
		// sequencing faults record the slot and drop enables
		for (int k = 0; k < 3; k++) begin
			sl = k ? 4'($urandom) : 4'hF;
			req_slot <= sl;
			req_seq <= 1'b1;
			evt("seq fault", 1'b1);
			rec(f_b0(sl, 4'h0), 12'h0);
			chk_bit("en off", 1'b1, en_out_off);
			req_start <= 1'b1;
			evt("seq start", 1'b0);
			chk_bit("en on", 1'b0, en_out_off);
		end
		$display("test sequencing done");
		// tracking faults only on closed-loop channels
		// log control 2 still means logging on
		bus(1'b1, flt_pkg::IDX_LOG_CTRL, 8'h02);
		rdc("log ctrl", flt_pkg::IDX_LOG_CTRL, 8'h02);
		bus(1'b1, flt_pkg::IDX_TRK_CLOSED_LOOP, 8'h05);
		for (int k = 0; k < 4; k++) begin
			req_trk <= 4'h1 << k;
			evt("tracking", k % 2 == 0);
			if (k % 2 == 0) rec(f_b0(4'h0, 4'h1 << k), 12'h0);
		end
		$display("test tracking done");
		// seq, tracking and crossing in one cycle land in one record
		req_slot <= 4'h9;
		req_seq <= 1'b1;
		req_trk <= 4'h1;
		req_ew[0] <= 1'b1;
		evt("coherent", 1'b1);
		rec(f_b0(4'h9, 4'h1), 12'h001);
		req_start <= 1'b1;
		evt("seq start", 1'b0);
		chk_bit("en on", 1'b0, en_out_off);
		$display("test coherent record done");
		// logging disabled, then interrupt cleared
		chk_bit("irq set", 1'b1, irq);
		bus(1'b1, flt_pkg::IDX_LOG_CTRL, 8'h03);
		req_slot <= 4'h2;
		req_seq <= 1'b1;
		evt("blocked", 1'b0);
		rec(f_b0(4'h9, 4'h1), 12'h001);
		chk_bit("en off blocked", 1'b1, en_out_off);
		rdc("irq status set", flt_pkg::IDX_IRQ_STATUS, 8'h07);
		bus(1'b1, flt_pkg::IDX_IRQ_STATUS, 8'hFF);
		rdc("irq status", flt_pkg::IDX_IRQ_STATUS, 8'h00);
		chk_bit("irq clear", 1'b0, irq);
		$display("test log control done");
		close_out();
	end
endmodule // test_flt_log_top
